//--- fieldbus_drive_command_decoder.sv
// Slave decoder for the cyclic master frame: control word, reference words and parameter channel.
// Assumes words arrive synchronous to mclk_in, first word flagged by frame_start_in.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - A cyclic frame is sixteen words of sixteen bits.
// - Four parameter-channel words come first, then process data.
// - Process data is applied before the parameter channel; valid data always held.
// - Drive is a slave with a fixed address; only the master starts exchanges.
// - The first process-data word is the control word.
// - Control word low byte is a command code, 1 through 8.
// - Control word bit 8 permits parameter writes.
// - Control word bits 9 and 10 pick one of four motor groups.
// - Bits 11 to 15 enable torque, energy clear, premagnetize, DC brake, heartbeat.
// - Words 2 to 12 are references chosen by per-word selection, 0 unused.
// - Selection 1 is set frequency, zero to maximum frequency.
// - Selections 2 and 3 are PID setpoint and feedback, 0 to 1000.
// - Selection 4 is signed torque setpoint, -3000 to 3000.
// - Selections 5 and 6 are forward and reverse frequency limits.
// - Selection 7 motoring torque limit to 3000; 8 braking limit to 2000.
// - Selection 9 virtual inputs to 0x1FF; 10 virtual outputs to 0x0F.
// - Selection 11 is V/F separation voltage, 0 to 1000.
// - Selections 12 and 13 are analog outputs, -1000 to 1000.
// - Selections 14 to 17 are position reference and feedback word pairs.
// - Position feedback loads only after its flag goes 1 then 0.
// - Run commands act only when the bus is the command source.
// - Control word and references are evaluated in every frame; the code evaluates only frames whose address matches station_addr_in.
// - Response carries the state word, run state in its low byte.
// - Parameter identifier 0 to 7 and address 0 to 247.
module fieldbus_drive_command_decoder
	import drive_cmd_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        reset_n_in,
	input  wire logic [6:0]  station_addr_in,
	input  wire logic [6:0]  frame_addr_in,
	input  wire logic        frame_start_in,
	input  wire logic        word_valid_in,
	input  wire logic [15:0] word_in,
	input  wire logic        cmd_source_is_bus_in,
	input  wire logic [15:0] fmax_in,
	input  wire logic [54:0] func_sel_in,
	input  wire logic [7:0]  run_state_in,
	input  wire logic [7:0]  state_flags_in,
	output logic             frame_done_out,
	output logic [15:0]      drive_state_word_out,
	output logic [7:0]       cmd_code_out,
	output logic             cmd_strobe_out,
	output logic             param_write_permit_out,
	output logic [1:0]       motor_group_out,
	output logic             torque_ctrl_en_out,
	output logic             energy_clear_out,
	output logic             premagnetize_flag_out,
	output logic             dc_brake_flag_out,
	output logic             heartbeat_en_out,
	output logic             param_req_out,
	output logic             param_write_out,
	output logic [15:0]      param_ident_word_out,
	output logic [15:0]      param_index_word_out,
	output logic [15:0]      param_value_word_one_out,
	output logic [15:0]      param_value_word_two_out,
	output logic [15:0]      set_freq_out,
	output logic [15:0]      pid_setpoint_out,
	output logic [15:0]      pid_feedback_out,
	output logic [15:0]      torque_set_out,
	output logic [15:0]      fwd_limit_out,
	output logic [15:0]      rev_limit_out,
	output logic [15:0]      motor_tq_limit_out,
	output logic [15:0]      brake_tq_limit_out,
	output logic [8:0]       virt_in_out,
	output logic [3:0]       virt_out_out,
	output logic [15:0]      vf_voltage_out,
	output logic [15:0]      analog_output_one_out,
	output logic [15:0]      analog_output_two_out,
	output logic [31:0]      pos_ref_out,
	output logic [31:0]      pos_fb_out,
	output logic             pos_fb_load_out
);
	dec_state_t        state_r;
	logic [3:0]        cnt_r;
	logic              addr_ok_r;
	logic [15:0]       words_r [FRAME_WORDS];
	logic [REF_SLOTS-1:0] slot_ok;
	logic              pos_flag_r;
	logic              pos_armed_r;
	logic [15:0]       cw;
	logic              take_word;
	logic [3:0]        wr_idx;
	logic [15:0]       freq_nxt, pids_nxt, pidf_nxt, tq_nxt, fwd_nxt, rev_nxt, mtq_nxt, btq_nxt;
	logic [15:0]       vin_nxt, vout_nxt, vf_nxt, ao1_nxt, ao2_nxt;
	logic [31:0]       pref_nxt, pfb_nxt;
	logic              pfb_seen, flag_seen, flag_val, pos_arm_now;

	assign cw        = words_r[CW_INDEX];
	assign take_word = word_valid_in && (frame_start_in || state_r == ST_RECV);
	assign wr_idx    = frame_start_in ? 4'h0 : cnt_r;

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			state_r   <= ST_IDLE;
			cnt_r     <= 4'h0;
			addr_ok_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE, ST_RECV: begin
					if (word_valid_in && frame_start_in) begin
						addr_ok_r <= (frame_addr_in == station_addr_in);
						cnt_r     <= CNT_AFTER_START;
						state_r   <= ST_RECV;
					end else if (take_word) begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == LAST_WORD) begin
							state_r <= addr_ok_r ? ST_APPLY_PD : ST_IDLE;
						end
					end
				end
				ST_APPLY_PD:    state_r <= ST_APPLY_PARAM;
				ST_APPLY_PARAM: state_r <= ST_IDLE;
				default:        state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (take_word) begin
			words_r[wr_idx] <= word_in;
		end
	end

	genvar g;
	generate
		for (g = 0; g < REF_SLOTS; g++) begin : g_slot
			ref_slot_check u_chk (
				.word_in (words_r[REF_FIRST+g]),
				.func_in (func_sel_in[g*FN_BITS +: FN_BITS]),
				.fmax_in (fmax_in),
				.ok_out  (slot_ok[g])
			);
		end
	endgenerate

	always_comb begin
		freq_nxt = set_freq_out;
		pids_nxt = pid_setpoint_out;
		pidf_nxt = pid_feedback_out;
		tq_nxt   = torque_set_out;
		fwd_nxt  = fwd_limit_out;
		rev_nxt  = rev_limit_out;
		mtq_nxt  = motor_tq_limit_out;
		btq_nxt  = brake_tq_limit_out;
		vin_nxt  = {7'h00, virt_in_out};
		vout_nxt = {12'h000, virt_out_out};
		vf_nxt   = vf_voltage_out;
		ao1_nxt  = analog_output_one_out;
		ao2_nxt  = analog_output_two_out;
		pref_nxt = pos_ref_out;
		pfb_nxt  = pos_fb_out;
		pfb_seen = 1'b0;
		flag_seen = 1'b0;
		flag_val = 1'b0;
		for (int i = 0; i < REF_SLOTS; i++) begin
			if (slot_ok[i]) begin
				case (func_sel_in[i*FN_BITS +: FN_BITS])
					FN_SET_FREQ: freq_nxt = words_r[REF_FIRST+i];
					FN_PID_SET:  pids_nxt = words_r[REF_FIRST+i];
					FN_PID_FB:   pidf_nxt = words_r[REF_FIRST+i];
					FN_TORQUE:   tq_nxt   = words_r[REF_FIRST+i];
					FN_FWD_LIM:  fwd_nxt  = words_r[REF_FIRST+i];
					FN_REV_LIM:  rev_nxt  = words_r[REF_FIRST+i];
					FN_MOT_TQ:   mtq_nxt  = words_r[REF_FIRST+i];
					FN_BRK_TQ:   btq_nxt  = words_r[REF_FIRST+i];
					FN_VIRT_IN:  vin_nxt  = words_r[REF_FIRST+i];
					FN_VIRT_OUT: vout_nxt = words_r[REF_FIRST+i];
					FN_VF_VOLT:  vf_nxt   = words_r[REF_FIRST+i];
					FN_AO_ONE:   ao1_nxt  = words_r[REF_FIRST+i];
					FN_AO_TWO:   ao2_nxt  = words_r[REF_FIRST+i];
					FN_PREF_MSW: pref_nxt[31:16] = words_r[REF_FIRST+i];
					FN_PREF_LSW: pref_nxt[15:0]  = words_r[REF_FIRST+i];
					FN_PFB_MSW: begin
						pfb_nxt[31:16] = words_r[REF_FIRST+i];
						pfb_seen = 1'b1;
					end
					FN_PFB_LSW: begin
						pfb_nxt[15:0] = words_r[REF_FIRST+i];
						pfb_seen = 1'b1;
					end
					FN_POS_FLAG: begin
						flag_seen = 1'b1;
						flag_val  = words_r[REF_FIRST+i][0];
					end
					default: freq_nxt = freq_nxt;
				endcase
			end
		end
		pos_arm_now = flag_seen && !flag_val && pos_flag_r;
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			set_freq_out          <= WORD_RESET;
			pid_setpoint_out      <= WORD_RESET;
			pid_feedback_out      <= WORD_RESET;
			torque_set_out        <= WORD_RESET;
			fwd_limit_out         <= WORD_RESET;
			rev_limit_out         <= WORD_RESET;
			motor_tq_limit_out    <= WORD_RESET;
			brake_tq_limit_out    <= WORD_RESET;
			virt_in_out           <= 9'h000;
			virt_out_out          <= 4'h0;
			vf_voltage_out        <= WORD_RESET;
			analog_output_one_out <= WORD_RESET;
			analog_output_two_out <= WORD_RESET;
			pos_ref_out           <= 32'h0000_0000;
		end else if (state_r == ST_APPLY_PD) begin
			set_freq_out          <= freq_nxt;
			pid_setpoint_out      <= pids_nxt;
			pid_feedback_out      <= pidf_nxt;
			torque_set_out        <= tq_nxt;
			fwd_limit_out         <= fwd_nxt;
			rev_limit_out         <= rev_nxt;
			motor_tq_limit_out    <= mtq_nxt;
			brake_tq_limit_out    <= btq_nxt;
			virt_in_out           <= vin_nxt[8:0];
			virt_out_out          <= vout_nxt[3:0];
			vf_voltage_out        <= vf_nxt;
			analog_output_one_out <= ao1_nxt;
			analog_output_two_out <= ao2_nxt;
			pos_ref_out           <= pref_nxt;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			pos_flag_r      <= 1'b0;
			pos_armed_r     <= 1'b0;
			pos_fb_out      <= 32'h0000_0000;
			pos_fb_load_out <= 1'b0;
		end else begin
			pos_fb_load_out <= 1'b0;
			if (state_r == ST_APPLY_PD) begin
				if (flag_seen) begin
					pos_flag_r <= flag_val;
				end
				// Arming in the same frame as a load wins, so a fresh edge is not lost.
				if (pos_arm_now) begin
					pos_armed_r <= 1'b1;
				end else if (pfb_seen && pos_armed_r) begin
					pos_armed_r <= 1'b0;
				end
				if (pfb_seen && pos_armed_r) begin
					pos_fb_out      <= pfb_nxt;
					pos_fb_load_out <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			cmd_code_out           <= CMD_RESET_VAL;
			cmd_strobe_out         <= 1'b0;
			param_write_permit_out <= 1'b0;
			motor_group_out        <= 2'h0;
			torque_ctrl_en_out     <= 1'b0;
			energy_clear_out       <= 1'b0;
			premagnetize_flag_out  <= 1'b0;
			dc_brake_flag_out      <= 1'b0;
			heartbeat_en_out       <= 1'b0;
			frame_done_out         <= 1'b0;
			drive_state_word_out   <= WORD_RESET;
		end else begin
			cmd_strobe_out <= 1'b0;
			frame_done_out <= (state_r == ST_APPLY_PD);
			if (state_r == ST_APPLY_PD) begin
				if (cmd_source_is_bus_in && cw[7:0] >= CMD_FWD_RUN && cw[7:0] <= CMD_JOG_STOP) begin
					cmd_code_out   <= cw[7:0];
					cmd_strobe_out <= 1'b1;
				end
				param_write_permit_out <= cw[CW_WRITE_BIT];
				motor_group_out <= cw[CW_GROUP_LSB +: 2];
				torque_ctrl_en_out    <= cw[CW_TORQUE_BIT];
				energy_clear_out      <= cw[CW_ENERGY_BIT];
				premagnetize_flag_out <= cw[CW_PREMAG_BIT];
				dc_brake_flag_out     <= cw[CW_DCBRK_BIT];
				heartbeat_en_out      <= cw[CW_HBEAT_BIT];
				drive_state_word_out <= {state_flags_in, run_state_in};
			end
		end
	end

	// The parameter channel trails the process data by one cycle so set-points never wait on it.
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			param_req_out            <= 1'b0;
			param_write_out          <= 1'b0;
			param_ident_word_out     <= WORD_RESET;
			param_index_word_out     <= WORD_RESET;
			param_value_word_one_out <= WORD_RESET;
			param_value_word_two_out <= WORD_RESET;
		end else begin
			param_req_out   <= 1'b0;
			param_write_out <= 1'b0;
			if (state_r == ST_APPLY_PARAM && words_r[0] <= PKW_IDENT_MAX && words_r[1] <= PKW_ADDR_MAX) begin
				param_req_out            <= 1'b1;
				param_write_out          <= param_write_permit_out;
				param_ident_word_out     <= words_r[0];
				param_index_word_out     <= words_r[1];
				param_value_word_one_out <= words_r[2];
				param_value_word_two_out <= words_r[3];
			end
		end
	end

	sequence s_last_word;
		word_valid_in && !frame_start_in && state_r == ST_RECV && cnt_r == LAST_WORD && addr_ok_r;
	endsequence
	sequence s_applied;
		##1 state_r == ST_APPLY_PD ##1 frame_done_out;
	endsequence

	property p_frame_len;
		@(posedge mclk_in) disable iff (!reset_n_in) s_last_word |-> s_applied;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame end not applied");

	property p_param_after_pd;
		@(posedge mclk_in) disable iff (!reset_n_in) param_req_out |-> $past(frame_done_out);
	endproperty
	a_param_after_pd: assert property (p_param_after_pd) else $error("parameter ahead of process data");

	property p_cmd_range;
		@(posedge mclk_in) disable iff (!reset_n_in)
			cmd_strobe_out |-> cmd_code_out >= CMD_FWD_RUN && cmd_code_out <= CMD_JOG_STOP;
	endproperty
	a_cmd_range: assert property (p_cmd_range) else $error("command code out of range");

	property p_cmd_source;
		@(posedge mclk_in) disable iff (!reset_n_in)
			(state_r == ST_APPLY_PD && !cmd_source_is_bus_in) |=> !cmd_strobe_out;
	endproperty
	a_cmd_source: assert property (p_cmd_source) else $error("command taken without bus source");

	property p_write_permit;
		@(posedge mclk_in) disable iff (!reset_n_in) param_write_out |-> param_write_permit_out && param_req_out;
	endproperty
	a_write_permit: assert property (p_write_permit) else $error("write without permit");

	property p_group;
		@(posedge mclk_in) disable iff (!reset_n_in)
			frame_done_out |-> motor_group_out == $past(cw[CW_GROUP_LSB +: 2]);
	endproperty
	a_group: assert property (p_group) else $error("motor group mismatch");

	property p_flags;
		@(posedge mclk_in) disable iff (!reset_n_in)
			frame_done_out |-> heartbeat_en_out == $past(cw[CW_HBEAT_BIT]) && torque_ctrl_en_out == $past(cw[CW_TORQUE_BIT]);
	endproperty
	a_flags: assert property (p_flags) else $error("enable flag mismatch");

	property p_pkw_range;
		@(posedge mclk_in) disable iff (!reset_n_in)
			param_req_out |-> param_ident_word_out <= PKW_IDENT_MAX && param_index_word_out <= PKW_ADDR_MAX;
	endproperty
	a_pkw_range: assert property (p_pkw_range) else $error("parameter channel out of range");

	property p_torque_range;
		@(posedge mclk_in) disable iff (!reset_n_in)
			$signed(torque_set_out) >= TQ_MIN && $signed(torque_set_out) <= TQ_MAX;
	endproperty
	a_torque_range: assert property (p_torque_range) else $error("torque setpoint out of range");

	property p_pos_load;
		@(posedge mclk_in) disable iff (!reset_n_in)
			pos_fb_load_out |-> $past(pos_armed_r) && $past(state_r == ST_APPLY_PD);
	endproperty
	a_pos_load: assert property (p_pos_load) else $error("position feedback loaded unarmed");
endmodule
`default_nettype wire

//--- drive_cmd_pkg.sv
// Shared constants for the fieldbus drive command decoder.
// Assumes one clock domain and a 16-word master frame delivered one word at a time.
package drive_cmd_pkg;
	localparam int        FRAME_WORDS   = 16;
	localparam int        CW_INDEX      = 4;
	localparam int        REF_FIRST     = 5;
	localparam int        REF_SLOTS     = 11;
	localparam int        FN_BITS       = 5;
	localparam logic [3:0] LAST_WORD    = 4'hF;
	localparam logic [3:0] CNT_AFTER_START = 4'h1;
	// Control word command codes.
	localparam logic [7:0] CMD_FWD_RUN  = 8'h01;
	localparam logic [7:0] CMD_JOG_STOP = 8'h08;
	localparam logic [7:0] CMD_RESET_VAL = 8'h00;
	// Control word bit positions.
	localparam int        CW_WRITE_BIT  = 8;
	localparam int        CW_GROUP_LSB  = 9;
	localparam int        CW_TORQUE_BIT = 11;
	localparam int        CW_ENERGY_BIT = 12;
	localparam int        CW_PREMAG_BIT = 13;
	localparam int        CW_DCBRK_BIT  = 14;
	localparam int        CW_HBEAT_BIT  = 15;
	// Reference word function selections.
	localparam logic [4:0] FN_NONE      = 5'h00;
	localparam logic [4:0] FN_SET_FREQ  = 5'h01;
	localparam logic [4:0] FN_PID_SET   = 5'h02;
	localparam logic [4:0] FN_PID_FB    = 5'h03;
	localparam logic [4:0] FN_TORQUE    = 5'h04;
	localparam logic [4:0] FN_FWD_LIM   = 5'h05;
	localparam logic [4:0] FN_REV_LIM   = 5'h06;
	localparam logic [4:0] FN_MOT_TQ    = 5'h07;
	localparam logic [4:0] FN_BRK_TQ    = 5'h08;
	localparam logic [4:0] FN_VIRT_IN   = 5'h09;
	localparam logic [4:0] FN_VIRT_OUT  = 5'h0A;
	localparam logic [4:0] FN_VF_VOLT   = 5'h0B;
	localparam logic [4:0] FN_AO_ONE    = 5'h0C;
	localparam logic [4:0] FN_AO_TWO    = 5'h0D;
	localparam logic [4:0] FN_PREF_MSW  = 5'h0E;
	localparam logic [4:0] FN_PREF_LSW  = 5'h0F;
	localparam logic [4:0] FN_PFB_MSW   = 5'h10;
	localparam logic [4:0] FN_PFB_LSW   = 5'h11;
	localparam logic [4:0] FN_POS_FLAG  = 5'h12;
	// Range limits.
	localparam logic [15:0] LIM_PERMILLE   = 16'h03E8;
	localparam logic [15:0] LIM_MOT_TQ     = 16'h0BB8;
	localparam logic [15:0] LIM_BRK_TQ     = 16'h07D0;
	localparam logic [15:0] LIM_VIRT_IN    = 16'h01FF;
	localparam logic [15:0] LIM_VIRT_OUT   = 16'h000F;
	localparam logic signed [15:0] TQ_MAX  = 16'sh0BB8;
	localparam logic signed [15:0] TQ_MIN  = 16'shF448;
	localparam logic signed [15:0] AO_MAX  = 16'sh03E8;
	localparam logic signed [15:0] AO_MIN  = 16'shFC18;
	localparam logic [15:0] FLAG_ONE       = 16'h0001;
	localparam logic [15:0] PKW_IDENT_MAX  = 16'h0007;
	localparam logic [15:0] PKW_ADDR_MAX   = 16'h00F7;
	localparam logic [15:0] WORD_RESET     = 16'h0000;
	typedef enum logic [1:0] {
		ST_IDLE        = 2'b00,
		ST_RECV        = 2'b01,
		ST_APPLY_PD    = 2'b10,
		ST_APPLY_PARAM = 2'b11
	} dec_state_t;
endpackage

//--- ref_slot_check.sv
// Range check for one reference word against its function selection.
// Assumes the word and selection are stable for the cycle they are judged in.
`timescale 1ns/100ps
`default_nettype none
module ref_slot_check
	import drive_cmd_pkg::*;
(
	input  wire logic [15:0] word_in,
	input  wire logic [4:0]  func_in,
	input  wire logic [15:0] fmax_in,
	output logic             ok_out
);
	always_comb begin
		case (func_in)
			FN_SET_FREQ, FN_FWD_LIM, FN_REV_LIM: ok_out = (word_in <= fmax_in);
			FN_PID_SET, FN_PID_FB, FN_VF_VOLT:   ok_out = (word_in <= LIM_PERMILLE);
			FN_TORQUE:   ok_out = ($signed(word_in) >= TQ_MIN) && ($signed(word_in) <= TQ_MAX);
			FN_MOT_TQ:   ok_out = (word_in <= LIM_MOT_TQ);
			FN_BRK_TQ:   ok_out = (word_in <= LIM_BRK_TQ);
			FN_VIRT_IN:  ok_out = (word_in <= LIM_VIRT_IN);
			FN_VIRT_OUT: ok_out = (word_in <= LIM_VIRT_OUT);
			FN_AO_ONE, FN_AO_TWO: ok_out = ($signed(word_in) >= AO_MIN) && ($signed(word_in) <= AO_MAX);
			FN_PREF_MSW, FN_PREF_LSW, FN_PFB_MSW, FN_PFB_LSW: ok_out = 1'b1;
			FN_POS_FLAG: ok_out = (word_in <= FLAG_ONE);
			// Selection 0 and undefined selections never steer a set-point.
			default:     ok_out = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

//--- master_frame_model.sv
// Behavioural fieldbus master that sends one 16-word cyclic frame per call.
// Assumes the caller runs in the bench's main process with the clock running.
`timescale 1ns/100ps
`default_nettype none
module master_frame_model (
	input  wire logic   mclk_in,
	output logic [6:0]  frame_addr_out,
	output logic        frame_start_out,
	output logic        word_valid_out,
	output logic [15:0] word_out
);
	initial begin
		frame_addr_out = 7'h00;
		frame_start_out = 1'b0;
		word_valid_out = 1'b0;
		word_out = 16'h0000;
	end
	task automatic send_frame(input logic [6:0] addr, input logic [255:0] f);
		for (int i = 0; i < 16; i++) begin
			@(negedge mclk_in);
			frame_addr_out = addr;
			frame_start_out = (i == 0);
			word_valid_out = 1'b1;
			word_out = f[16*i +: 16];
		end
		@(negedge mclk_in);
		frame_start_out = 1'b0;
		word_valid_out = 1'b0;
		// The released bus shows the inverse, so stale data cannot pass for a match.
		word_out = ~word_out;
	endtask
endmodule
`default_nettype wire

//--- fieldbus_drive_command_decoder_bench.sv
// Self-checking bench for the fieldbus drive command decoder.
// Assumes the master model sends frames; the bench drives levels at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_drive_command_decoder_bench;
	import drive_cmd_pkg::*;
	logic        mclk_in, reset_n_in, frame_start_in, word_valid_in, cmd_source_is_bus_in;
	logic [6:0]  station_addr_in, frame_addr_in;
	logic [15:0] word_in, fmax_in;
	logic [54:0] func_sel_in;
	logic [7:0]  run_state_in, state_flags_in, cmd_code_out;
	logic        frame_done_out, cmd_strobe_out, param_write_permit_out, torque_ctrl_en_out, energy_clear_out;
	logic        premagnetize_flag_out, dc_brake_flag_out, heartbeat_en_out, param_req_out, param_write_out;
	logic        pos_fb_load_out;
	logic [1:0]  motor_group_out;
	logic [15:0] drive_state_word_out, param_ident_word_out, param_index_word_out, param_value_word_one_out;
	logic [15:0] param_value_word_two_out, set_freq_out, pid_setpoint_out, pid_feedback_out, torque_set_out;
	logic [15:0] fwd_limit_out, rev_limit_out, motor_tq_limit_out, brake_tq_limit_out, vf_voltage_out;
	logic [15:0] analog_output_one_out, analog_output_two_out;
	logic [8:0]  virt_in_out;
	logic [3:0]  virt_out_out;
	logic [31:0] pos_ref_out, pos_fb_out;
	logic        strobe, preq, pwr, load;
	int          bad_count, checks;

	always #5 mclk_in = ~mclk_in;

	master_frame_model u_master (
		.mclk_in         (mclk_in),
		.frame_addr_out  (frame_addr_in),
		.frame_start_out (frame_start_in),
		.word_valid_out  (word_valid_in),
		.word_out        (word_in)
	);
	fieldbus_drive_command_decoder u_dut (.*);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Sends one frame and samples the apply pulses; a missing expected pulse ends the run.
	task automatic run_frame(input logic [6:0] addr, input logic [255:0] f, input bit expect_done);
		int i;
		u_master.send_frame(addr, f);
		for (i = 0; i < 6; i++) begin
			@(negedge mclk_in);
			if (frame_done_out === 1'b1)
				break;
		end
		strobe = cmd_strobe_out;
		load = pos_fb_load_out;
		@(negedge mclk_in);
		preq = param_req_out;
		pwr = param_write_out;
		if (expect_done && i == 6) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, 32'h6, 32'h0);
			test_done();
		end
		chk(i, expect_done ? 32'h0 : 32'h6);
	endtask

	initial begin
		mclk_in = 1'b0;
		reset_n_in = 1'b0;
		cmd_source_is_bus_in = 1'b1;
		station_addr_in = 7'h02;
		fmax_in = 16'h2710;
		run_state_in = 8'h05;
		state_flags_in = 8'hA0;
		func_sel_in = {25'h0, FN_NONE, FN_VIRT_OUT, FN_VIRT_IN, FN_BRK_TQ, FN_TORQUE, FN_SET_FREQ};
		bad_count = 0;
		checks = 0;
		repeat (8) @(negedge mclk_in);
		chk(cmd_code_out, 32'h0);
		chk(frame_done_out, 32'h0);
		reset_n_in = 1'b1;
		$display("test reset done");
		run_frame(7'h02, {80'h0, 16'h1234, 16'h000F, 16'h01FF, 16'h07D1, 16'hF448, 16'h1388, 16'hAD03,
			16'h0042, 16'hBEEF, 16'h00F7, 16'h0007}, 1'b1);
		chk(strobe, 32'h1);
		chk(cmd_code_out, 32'h3);
		chk(param_write_permit_out, 32'h1);
		chk(motor_group_out, 32'h2);
		chk({heartbeat_en_out, dc_brake_flag_out, premagnetize_flag_out, energy_clear_out,
			torque_ctrl_en_out}, 32'h15);
		chk(set_freq_out, 32'h1388);
		chk(torque_set_out, 32'hF448);
		chk(brake_tq_limit_out, 32'h0);
		chk(virt_in_out, 32'h1FF);
		chk(virt_out_out, 32'hF);
		chk(drive_state_word_out, 32'hA005);
		chk({preq, pwr}, 32'h3);
		chk({param_ident_word_out, param_index_word_out}, 32'h000700F7);
		chk({param_value_word_one_out, param_value_word_two_out}, 32'hBEEF0042);
		$display("test valid frame done");
		run_frame(7'h02, {160'h0, 16'h2711, 16'h0009, 48'h0, 16'h0008}, 1'b1);
		chk(strobe, 32'h0);
		chk(cmd_code_out, 32'h3);
		chk(param_write_permit_out, 32'h0);
		chk(set_freq_out, 32'h1388);
		chk(torque_set_out, 32'h0);
		chk(preq, 32'h0);
		$display("test refused values done");
		run_frame(7'h05, {176'h0, 16'h0001, 64'h0}, 1'b0);
		chk({strobe, preq}, 32'h0);
		chk(cmd_code_out, 32'h3);
		$display("test foreign address done");
		cmd_source_is_bus_in = 1'b0;
		run_frame(7'h02, {176'h0, 16'h0001, 64'h0}, 1'b1);
		chk(strobe, 32'h0);
		chk(cmd_code_out, 32'h3);
		$display("test command source done");
		func_sel_in = {FN_POS_FLAG, FN_PREF_LSW, FN_PREF_MSW, FN_AO_TWO, FN_AO_ONE, FN_VF_VOLT, FN_MOT_TQ, FN_REV_LIM,
			FN_FWD_LIM, FN_PID_FB, FN_PID_SET};
		run_frame(7'h02, {16'h0001, 16'h5678, 16'h8001, 16'hFC18, 16'h03E9, 16'h03E8, 16'h0BB8, 16'h2710, 16'h0001,
			16'h03E9, 16'h03E8, 80'h0}, 1'b1);
		chk(pid_setpoint_out, 32'h3E8);
		chk(pid_feedback_out, 32'h0);
		chk({fwd_limit_out, rev_limit_out}, 32'h00012710);
		chk(motor_tq_limit_out, 32'hBB8);
		chk(vf_voltage_out, 32'h3E8);
		chk({analog_output_one_out, analog_output_two_out}, 32'h0000FC18);
		chk(pos_ref_out, 32'h80015678);
		$display("test set-point selections done");
		func_sel_in = {FN_POS_FLAG, FN_PFB_LSW, FN_PFB_MSW, 40'h0};
		run_frame(7'h02, {16'h0000, 16'hBBBB, 16'hAAAA, 112'h0, 16'h0123, 80'h0}, 1'b1);
		chk(pid_setpoint_out, 32'h3E8);
		chk(load, 32'h0);
		chk(pos_fb_out, 32'h0);
		run_frame(7'h02, {16'h0000, 16'hBBBB, 16'hAAAA, 112'h0, 16'h0123, 80'h0}, 1'b1);
		chk(load, 32'h1);
		chk(pos_fb_out, 32'hAAAABBBB);
		$display("test position feedback done");
		test_done();
	end
endmodule
`default_nettype wire
